// >>> core/spi_cmd_decoder.sv
// Serial command decoder for the radio and converter subsystem registers
`timescale 1ns/1ps
module spi_cmd_decoder
  import spi_cmd_pkg::*;
#(
  parameter int N_CFG  = CFG_BYTES,
  parameter int N_TXA  = TXA_BYTES,
  parameter int N_PAY  = PAY_BYTES,
  parameter int N_ADCC = ADC_CFG_BYTES,
  parameter int DEPTH  = FIFO_DEPTH
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_sck,
  input  wire logic                   i_mosi,
  input  wire logic                   i_csn,
  output logic                        o_miso,
  output logic                        o_miso_oe,
  input  wire logic [7:0]             i_status,
  input  wire logic [N_PAY-1:0][7:0]  i_rx_payload,
  input  wire logic [ADC_RES_BYTES-1:0][7:0] i_converter_result,
  input  wire logic                   i_store_hold,
  output logic                        o_store_ready,
  output logic [N_CFG-1:0][7:0]       o_radio_setup,
  output logic [N_TXA-1:0][7:0]       o_tx_address,
  output logic [N_PAY-1:0][7:0]       o_tx_payload,
  output logic [N_ADCC-1:0][7:0]      o_converter_setup,
  output logic [3:0]                  o_converter_source_select,
  output logic                        o_convert_start
);

  state_t       state_reg;
  logic         sck_prev_reg;
  logic         csn_prev_reg;
  logic [6:0]   rx_sh_reg;
  logic [2:0]   bit_cnt_reg;
  logic [7:0]   tx_sh_reg;
  logic [7:0]   next_tx_reg;
  target_t      target_reg;
  logic [5:0]   index_reg;
  logic [3:0]   nibble_reg;
  logic         push_valid_reg;
  store_entry_t push_entry_reg;
  logic         conv_pending_reg;

  logic         cs_fall;
  logic         cs_rise;
  logic         sck_rise;
  logic         sck_fall;
  logic         byte_done;
  logic [7:0]   byte_val;
  op_info_t     op;
  logic         fifo_in_ready;
  logic         fifo_out_valid;
  logic [ENTRY_W-1:0] fifo_out_bits;
  store_entry_t drain;
  logic         drain_fire;

  assign cs_fall   = csn_prev_reg & ~i_csn;
  assign cs_rise   = ~csn_prev_reg & i_csn;
  assign sck_rise  = ~sck_prev_reg & i_sck & ~i_csn;
  assign sck_fall  = sck_prev_reg & ~i_sck & ~i_csn;
  assign byte_done = sck_rise && (bit_cnt_reg == 3'h7);
  assign byte_val  = {rx_sh_reg, i_mosi};
  assign op        = decode_opcode(byte_val);

  function automatic op_info_t decode_opcode(input logic [7:0] b);
    op_info_t r;
    r = '{valid: 1'b1, write: 1'b0, chan: 1'b0, conv: 1'b0, target: TGT_CFG, start: 6'h00};
    if (b[7:4] == OP_WR_CFG) begin
      r.write = 1'b1;
      r.start = {2'b00, b[3:0]};
    end else if (b[7:4] == OP_RD_CFG) begin
      r.start = {2'b00, b[3:0]};
    end else if (b == OP_WR_TXP) begin
      r.write  = 1'b1;
      r.target = TGT_TXP;
    end else if (b == OP_RD_TXP) begin
      r.target = TGT_TXP;
    end else if (b == OP_WR_TXA) begin
      r.write  = 1'b1;
      r.target = TGT_TXA;
    end else if (b == OP_RD_TXA) begin
      r.target = TGT_TXA;
    end else if (b == OP_RD_RXP) begin
      r.target = TGT_RXP;
    end else if (b[7:1] == OP_RD_ADC) begin
      r.target = TGT_RES;
      r.start  = {5'h00, b[0]};
    end else if (b == OP_WR_ADC) begin
      r.write  = 1'b1;
      r.target = TGT_ADC;
    end else if (b == OP_RD_ADC_C) begin
      r.target = TGT_ADC;
    end else if (b[7:4] == OP_CHAN) begin
      r.chan   = 1'b1;
      r.target = TGT_CHAN;
    end else if (b[7:4] == OP_CONV) begin
      r.conv = 1'b1;
    end else begin
      r.valid = 1'b0;
    end
    return r;
  endfunction : decode_opcode

  // Bytes past the end of a register read back as zero rather than wrapping, except the converter result, which wraps on index bit 0
  function automatic logic [7:0] read_byte(input target_t t, input logic [5:0] i);
    logic [7:0] r;
    r = BYTE_RESET;
    unique case (t)
      TGT_CFG:  if (int'(i) < N_CFG) r = o_radio_setup[i];
      TGT_TXA:  if (int'(i) < N_TXA) r = o_tx_address[i];
      TGT_TXP:  if (int'(i) < N_PAY) r = o_tx_payload[i];
      TGT_RXP:  if (int'(i) < N_PAY) r = i_rx_payload[i];
      TGT_ADC:  if (int'(i) < N_ADCC && int'(i) != ADC_RSVD_BYTE) r = o_converter_setup[i];
      TGT_RES:  r = i_converter_result[i[0]];
      TGT_CHAN: r = BYTE_RESET;
    endcase
    return r;
  endfunction : read_byte

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sck_prev_reg <= 1'b0;
      csn_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= i_sck;
      csn_prev_reg <= i_csn;
    end
  end

  // Bit counter restarts with every frame, so a cut-short byte never completes
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_sh_reg   <= '0;
      bit_cnt_reg <= '0;
    end else if (i_csn || cs_fall) begin
      bit_cnt_reg <= '0;
    end else if (sck_rise) begin
      rx_sh_reg   <= byte_val[6:0];
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg  <= ST_IDLE;
      target_reg <= TGT_CFG;
      index_reg  <= '0;
      nibble_reg <= '0;
    end else if (cs_fall) begin
      state_reg <= ST_CMD;
    end else if (i_csn) begin
      state_reg <= ST_IDLE;
    end else if (byte_done) begin
      unique case (state_reg)
        ST_CMD: begin
          target_reg <= op.target;
          index_reg  <= op.start + (op.write ? 6'h00 : 6'h01);
          nibble_reg <= byte_val[3:0];
          if (!op.valid || op.conv) begin
            state_reg <= ST_IGNORE;
          end else if (op.chan) begin
            state_reg <= ST_CHAN;
          end else if (op.write) begin
            state_reg <= ST_WRITE;
          end else begin
            state_reg <= ST_READ;
          end
        end
        ST_WRITE, ST_READ: begin
          index_reg <= index_reg + 6'h01;
        end
        ST_CHAN: begin
          state_reg <= ST_IGNORE;
        end
        ST_IDLE, ST_IGNORE: begin
          state_reg <= state_reg;
        end
      endcase
    end
  end

  // Next read byte is fetched at byte end, half a clock ahead of its first bit
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_sh_reg   <= BYTE_RESET;
      next_tx_reg <= BYTE_RESET;
    end else if (cs_fall) begin
      tx_sh_reg <= i_status;
    end else begin
      if (byte_done) begin
        if (state_reg == ST_CMD && op.valid && !op.write && !op.chan && !op.conv) begin
          next_tx_reg <= read_byte(op.target, op.start);
        end else if (state_reg == ST_READ) begin
          next_tx_reg <= read_byte(target_reg, index_reg);
        end else begin
          next_tx_reg <= BYTE_RESET;
        end
      end
      if (sck_fall) begin
        if (bit_cnt_reg == 3'h0) begin
          tx_sh_reg <= next_tx_reg;
        end else begin
          tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end else begin
      o_miso    <= cs_fall ? i_status[7] : (sck_fall && bit_cnt_reg == 3'h0) ? next_tx_reg[7] :
                   sck_fall ? tx_sh_reg[6] : tx_sh_reg[7];
      o_miso_oe <= ~i_csn;
    end
  end

  // Written bytes queue toward storage; full queue drops the byte
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      push_valid_reg <= 1'b0;
      push_entry_reg <= '0;
    end else begin
      push_valid_reg <= byte_done && !i_csn && (state_reg == ST_WRITE || state_reg == ST_CHAN);
      if (byte_done) begin
        push_entry_reg <= '{target: target_reg, index: index_reg, nibble: nibble_reg, data: byte_val};
      end
    end
  end

  store_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (DEPTH)
  ) u_store_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (push_valid_reg),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (push_entry_reg),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (~i_store_hold),
    .o_out_data  (fifo_out_bits)
  );

  assign drain      = store_entry_t'(fifo_out_bits);
  assign drain_fire = fifo_out_valid & ~i_store_hold;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_store_ready <= 1'b1;
    end else begin
      o_store_ready <= fifo_in_ready;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_radio_setup     <= '0;
      o_tx_address      <= '0;
      o_tx_payload      <= '0;
      o_converter_setup <= '0;
    end else if (drain_fire) begin
      unique case (drain.target)
        TGT_CFG: if (int'(drain.index) < N_CFG) o_radio_setup[drain.index] <= drain.data;
        TGT_TXA: if (int'(drain.index) < N_TXA) o_tx_address[drain.index] <= drain.data;
        TGT_TXP: if (int'(drain.index) < N_PAY) o_tx_payload[drain.index] <= drain.data;
        TGT_ADC: if (int'(drain.index) < N_ADCC && int'(drain.index) != ADC_RSVD_BYTE)
          o_converter_setup[drain.index] <= drain.data;
        TGT_CHAN: begin
          o_radio_setup[0] <= drain.data;
          o_radio_setup[1][PWR_LSB_POS+1:CHAN_MSB_POS] <= drain.nibble[CHAN_FLD_W-1:0];
        end
        TGT_RXP, TGT_RES: begin
          o_radio_setup <= o_radio_setup;
        end
      endcase
    end
  end

  // Start is held until select rises so the converter sees a closed frame
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      conv_pending_reg          <= 1'b0;
      o_converter_source_select <= SRC_RESET;
      o_convert_start           <= 1'b0;
    end else begin
      o_convert_start <= cs_rise & conv_pending_reg;
      if (byte_done && state_reg == ST_CMD && op.conv) begin
        o_converter_source_select <= byte_val[3:0];
        conv_pending_reg          <= 1'b1;
      end else if (cs_rise) begin
        conv_pending_reg <= 1'b0;
      end
    end
  end

endmodule : spi_cmd_decoder

// >>> shared/spi_cmd_pkg.sv
// Constants, types and the operation summary for the subsystem command decoder
package spi_cmd_pkg;

  localparam int CFG_BYTES      = 10;
  localparam int TXA_BYTES      = 4;
  localparam int PAY_BYTES      = 32;
  localparam int ADC_CFG_BYTES  = 3;
  localparam int ADC_RES_BYTES  = 2;
  localparam int ADC_RSVD_BYTE  = 2;
  localparam int FIFO_DEPTH     = 4;

  localparam logic [3:0] OP_WR_CFG   = 4'h0;
  localparam logic [3:0] OP_RD_CFG   = 4'h1;
  localparam logic [7:0] OP_WR_TXP   = 8'h20;
  localparam logic [7:0] OP_RD_TXP   = 8'h21;
  localparam logic [7:0] OP_WR_TXA   = 8'h22;
  localparam logic [7:0] OP_RD_TXA   = 8'h23;
  localparam logic [7:0] OP_RD_RXP   = 8'h24;
  localparam logic [6:0] OP_RD_ADC   = 7'h20;
  localparam logic [7:0] OP_WR_ADC   = 8'h44;
  localparam logic [7:0] OP_RD_ADC_C = 8'h46;
  localparam logic [3:0] OP_CHAN     = 4'h8;
  localparam logic [3:0] OP_CONV     = 4'hc;

  // Channel command fields inside setup byte 1
  localparam int CHAN_MSB_POS = 0;
  localparam int BAND_POS     = 1;
  localparam int PWR_LSB_POS  = 2;
  localparam int CHAN_FLD_W   = 4;

  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic [3:0] SRC_RESET    = 4'h0;

  typedef enum logic [2:0] {
    TGT_CFG  = 3'h0,
    TGT_TXA  = 3'h1,
    TGT_TXP  = 3'h2,
    TGT_ADC  = 3'h3,
    TGT_CHAN = 3'h4,
    TGT_RXP  = 3'h5,
    TGT_RES  = 3'h6
  } target_t;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_CMD    = 6'b000010,
    ST_WRITE  = 6'b000100,
    ST_READ   = 6'b001000,
    ST_CHAN   = 6'b010000,
    ST_IGNORE = 6'b100000
  } state_t;

  typedef struct packed {
    target_t    target;
    logic [5:0] index;
    logic [3:0] nibble;
    logic [7:0] data;
  } store_entry_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       chan;
    logic       conv;
    target_t    target;
    logic [5:0] start;
  } op_info_t;

  localparam int ENTRY_W = $bits(store_entry_t);

endpackage : spi_cmd_pkg

// >>> core/store_fifo.sv
// Small flip-flop FIFO between the serial decoder and register storage
`timescale 1ns/1ps
module store_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_reg != CNT_FULL);
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule : store_fifo

// >>> core/placeholder_none.sv
// Intentionally empty of logic: no further design units
`timescale 1ns/1ps

// >>> test/spi_cmd_decoder_asserts.sv
// Port-level checker for the serial command decoder
`timescale 1ns/1ps
module spi_cmd_decoder_checker (
  input wire logic       i_sys_clk,
  input wire logic       i_reset_n,
  input wire logic       i_sck,
  input wire logic       i_csn,
  input wire logic [7:0] i_status,
  input wire logic       i_store_hold,
  input wire logic       o_miso,
  input wire logic       o_miso_oe,
  input wire logic       o_store_ready,
  input wire logic [3:0] o_converter_source_select,
  input wire logic       o_convert_start
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  property p_oe_on; $fell(i_csn) |=> o_miso_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("miso enable not raised");
  property p_oe_off; $rose(i_csn) |=> !o_miso_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("miso enable not dropped");
  property p_status_msb; $fell(i_csn) |=> o_miso == $past(i_status[7]); endproperty
  a_status_msb: assert property (p_status_msb) else $error("status msb missing");
  property p_miso_edge;
    !i_csn && !$past(i_csn) && !$past(i_csn, 2) && $changed(o_miso) |-> $past(i_sck, 2) && !$past(i_sck);
  endproperty
  a_miso_edge: assert property (p_miso_edge) else $error("miso moved off sck fall");
  property p_conv_after_cs; o_convert_start |-> $past(i_csn) && !$past(i_csn, 2); endproperty
  a_conv_after_cs: assert property (p_conv_after_cs) else $error("start not after select rise");
  property p_conv_pulse; o_convert_start |=> !o_convert_start; endproperty
  a_conv_pulse: assert property (p_conv_pulse) else $error("start pulse too long");
  property p_src_in_frame; $changed(o_converter_source_select) |-> !$past(i_csn); endproperty
  a_src_in_frame: assert property (p_src_in_frame) else $error("source changed outside frame");
  property p_ready_back; $fell(i_store_hold) |-> ##[1:40] o_store_ready; endproperty
  a_ready_back: assert property (p_ready_back) else $error("store ready not regained");
endmodule : spi_cmd_decoder_checker

bind spi_cmd_decoder spi_cmd_decoder_checker u_chk (
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_sck(i_sck), .i_csn(i_csn),
  .i_status(i_status), .i_store_hold(i_store_hold), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
  .o_store_ready(o_store_ready), .o_converter_source_select(o_converter_source_select),
  .o_convert_start(o_convert_start)
);

// >>> test/mcu_spi_model.sv
// Port-pin controller model that drives the subsystem serial link
`timescale 1ns/1ps
module mcu_spi_model (
  input  wire logic i_sys_clk,
  input  wire logic i_miso,
  output logic      o_sck,
  output logic      o_mosi,
  output logic      o_csn
);
  // Sys cycles per sck phase; raise to act as a slow controller
  int half = 3;
  initial begin
    o_sck  = 1'b0;
    o_mosi = 1'b0;
    o_csn  = 1'b1;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : wait_n
  task automatic cs_low();
    @(negedge i_sys_clk);
    o_csn = 1'b0;
    wait_n(half);
  endtask : cs_low
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nb; i++) begin
      o_mosi = tx[7-i];
      wait_n(half);
      rx[7-i] = i_miso;
      o_sck = 1'b1;
      wait_n(half);
      o_sck = 1'b0;
    end
  endtask : xfer
  task automatic cs_high();
    wait_n(half);
    o_csn  = 1'b1;
    // Hold time over: data line no longer meaningful
    o_mosi = ~o_mosi;
    wait_n(half);
  endtask : cs_high
endmodule : mcu_spi_model

// >>> test/radio_adc_spi_command_decoder_bench.sv
// Self-checking bench for the serial command decoder
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module radio_adc_spi_command_decoder_bench;
  import spi_cmd_pkg::*;
  logic                         i_sys_clk, i_reset_n, sck, mosi, csn, miso, miso_oe;
  logic                         store_hold, store_ready, conv_start;
  logic [7:0]                   status, st_rx;
  logic [PAY_BYTES-1:0][7:0]    rx_pay, tx_pay;
  logic [ADC_RES_BYTES-1:0][7:0] res;
  logic [CFG_BYTES-1:0][7:0]    cfg;
  logic [TXA_BYTES-1:0][7:0]    txa;
  logic [ADC_CFG_BYTES-1:0][7:0] adcc;
  logic [3:0]                   src;
  logic [7:0]                   wb[8];
  logic [7:0]                   rb[8];
  int                           err_count = 0;
  int                           n_tests = 0;
  int                           n_conv = 0;

  spi_cmd_decoder dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_sck(sck), .i_mosi(mosi),
    .i_csn(csn), .o_miso(miso), .o_miso_oe(miso_oe), .i_status(status), .i_rx_payload(rx_pay),
    .i_converter_result(res), .i_store_hold(store_hold), .o_store_ready(store_ready),
    .o_radio_setup(cfg), .o_tx_address(txa), .o_tx_payload(tx_pay), .o_converter_setup(adcc),
    .o_converter_source_select(src), .o_convert_start(conv_start));
  mcu_spi_model u_mcu (.i_sys_clk(i_sys_clk), .i_miso(miso), .o_sck(sck), .o_mosi(mosi), .o_csn(csn));

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) if (conv_start === 1'b1) n_conv++;

  task automatic tally_and_finish();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // One framed instruction: opcode, then n data bytes out of wb into rb
  task automatic frame(input logic [7:0] op, input int n);
    logic [7:0] r;
    u_mcu.cs_low();
    u_mcu.xfer(op, 8, st_rx);
    for (int i = 0; i < n; i++) begin
      u_mcu.xfer(wb[i], 8, r);
      rb[i] = r;
    end
    u_mcu.cs_high();
  endtask : frame

  initial begin
    #(25ns * 20000);
    err_count++;
    tally_and_finish();
  end

  initial begin
    i_reset_n  = 1'b0;
    status     = 8'ha5;
    store_hold = 1'b0;
    res        = {8'hb2, 8'hb1};
    for (int i = 0; i < PAY_BYTES; i++) rx_pay[i] = 8'h80 + 8'(i);
    repeat (10) @(negedge i_sys_clk);
    `CHK({miso_oe, store_ready, conv_start, src}, 7'h20)
    `CHK(cfg, '0)
    i_reset_n = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    wb = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
    frame(8'h03, 2);
    `CHK(st_rx, 8'ha5)
    `CHK({cfg[4], cfg[3], cfg[2]}, 24'h221100)
    u_mcu.half = 5;
    frame(8'h13, 2);
    u_mcu.half = 3;
    `CHK({rb[0], rb[1]}, 16'h1122)
    frame(OP_WR_TXP, 3);
    `CHK({tx_pay[2], tx_pay[1], tx_pay[0]}, 24'h332211)
    frame(OP_RD_TXP, 3);
    `CHK({rb[0], rb[1], rb[2]}, 24'h112233)
    frame(OP_WR_TXA, 4);
    `CHK(txa, {8'h44, 8'h33, 8'h22, 8'h11})
    frame(OP_RD_TXA, 4);
    `CHK({rb[0], rb[1], rb[2], rb[3]}, 32'h11223344)
    frame(OP_RD_RXP, 3);
    `CHK({rb[0], rb[1], rb[2]}, 24'h808182)
    frame(8'h41, 2);
    `CHK({rb[0], rb[1]}, 16'hb2b1)
    frame(8'h40, 2);
    `CHK({rb[0], rb[1]}, 16'hb1b2)
    frame(OP_WR_ADC, 3);
    `CHK(adcc, {8'h00, 8'h22, 8'h11})
    frame(OP_RD_ADC_C, 3);
    `CHK({rb[0], rb[1], rb[2]}, 24'h112200)
    wb[0] = 8'h6c;
    frame(8'h8b, 1);
    `CHK({cfg[1][3:0], cfg[0]}, 12'hb6c)
    frame(8'hc5, 0);
    repeat (3) @(negedge i_sys_clk);
    `CHK(src, 4'h5)
    `CHK(n_conv, 1)
    wb[0] = 8'hff;
    frame(8'h30, 1);
    `CHK(rb[0], 8'h00)
    `CHK({cfg[3], txa[0]}, 16'h1111)
    u_mcu.cs_low();
    u_mcu.xfer(8'h05, 8, st_rx);
    u_mcu.xfer(8'h77, 8, st_rx);
    u_mcu.xfer(8'haa, 4, st_rx);
    u_mcu.cs_high();
    repeat (4) @(negedge i_sys_clk);
    `CHK({cfg[6], cfg[5]}, 16'h0077)
    // Storage stalled: only the first four bytes can be buffered
    wb = '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hd7};
    store_hold = 1'b1;
    frame(OP_WR_TXP, 6);
    `CHK(store_ready, 1'b0)
    store_hold = 1'b0;
    repeat (20) @(negedge i_sys_clk);
    `CHK(store_ready, 1'b1)
    `CHK({tx_pay[4], tx_pay[3], tx_pay[0]}, 24'h00d3d0)
    tally_and_finish();
  end
endmodule : radio_adc_spi_command_decoder_bench
